// [modem_model.sv]
`timescale 1ns/1ps
module modem_model (
  // frame control
  input wire logic run_i,
  input wire logic tx_bit_i,
  input wire logic [39:0] rx_data_i,
  // link pins
  output logic bit_clk_o,
  output logic rx_bit_o,
  output logic [15:0] cap_o
);
  int n = 0;
  logic armed = 1'b0;
  initial begin
    bit_clk_o = 1'b0;
    rx_bit_o = 1'b0;
    cap_o = 16'h0;
  end
  // bit clock still outside frames
  always begin
    #62.5;
    if (bit_clk_o) begin
      bit_clk_o = 1'b0;
      cap_o = {cap_o[14:0], tx_bit_i};
    end else if (run_i && armed) begin
      bit_clk_o = 1'b1;
      n = n + 1;
    end
    armed = run_i;
    if (!run_i) n = 0;
    if (!bit_clk_o) rx_bit_o = run_i ? rx_data_i[39 - n] : ~rx_bit_o;
  end
endmodule

// [packet_fifo_asserts.sv]
`timescale 1ns/1ps
`include "packet_fifo_map.svh"
module packet_fifo_asserts #(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // pins and flags
  input wire logic spi_cs_n_i,
  input wire logic tx_bit_o,
  input wire logic queue_vacant_o,
  input wire logic queue_all_occupied_o,
  input wire logic queue_level_indicator_o,
  input wire logic queue_overflow_flag_o,
  input wire logic pattern_match_flag_o,
  input wire logic op_mode_settled_o
);
  logic [1:0] mode_r;
  logic wm;
  logic ws;
  assign wm = wr_i && addr_i == `REG_MODE;
  assign ws = wr_i && addr_i == `REG_STATUS;
  // programmed mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= 2'h1;
    end else if (wm) begin
      mode_r <= wdata_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////
  a_flags_exclusive: assert property (
    spi_cs_n_i [*4] |-> !(queue_vacant_o && queue_all_occupied_o))
    else $error("vacant and full together");
  a_ovf_on_full: assert property (
    wr_i && addr_i == `REG_DATA && queue_all_occupied_o && !mode_r[1]
    |=> queue_overflow_flag_o) else $error("overflow not set");
  a_ovf_sticky: assert property (
    queue_overflow_flag_o && !ws && !wm |=> queue_overflow_flag_o)
    else $error("overflow dropped");
  a_ovf_flush: assert property (
    spi_cs_n_i [*4] ##0 (ws && wdata_i[`ST_OVF] && !mode_r[1])
    |=> !queue_overflow_flag_o && queue_vacant_o)
    else $error("overflow clear failed");
  a_level_hold: assert property (
    wr_i && addr_i == `REG_LIMIT && !mode_r[1]
    |=> $stable(queue_level_indicator_o)) else $error("level moved");
  a_settle_dip: assert property (
    wm && wdata_i[1:0] != mode_r |=> !op_mode_settled_o ##1
    op_mode_settled_o) else $error("settled dip wrong");
  a_match_drop: assert property (
    wm && mode_r == 2'h3 && wdata_i[1:0] != 2'h3
    |=> !pattern_match_flag_o) else $error("match kept");
  a_rx_flush: assert property (
    spi_cs_n_i [*4] ##0 (wm && wdata_i[1:0] == 2'h3 && mode_r != 2'h3)
    |=> queue_vacant_o) else $error("queue kept entering rx");
  a_tx_quiet: assert property (
    mode_r < 2'h2 && $past(mode_r, 4) < 2'h2 |-> $stable(tx_bit_o))
    else $error("tx bit moved while idle");
endmodule
bind packet_fifo_sync_detect packet_fifo_asserts #(.DEPTH(DEPTH)) watch (.*);

// [packet_fifo_map.svh]
`ifndef PACKET_FIFO_MAP_SVH
`define PACKET_FIFO_MAP_SVH

// register offsets
`define REG_DATA 8'h00
`define REG_STATUS 8'h04
`define REG_LIMIT 8'h08
`define REG_PAT_CFG 8'h0C
`define REG_PAT_LO 8'h10
`define REG_PAT_HI 8'h14
`define REG_MODE 8'h18

// status fields
`define ST_VACANT 0
`define ST_FULL 1
`define ST_LEVEL 2
`define ST_OVF 3
`define ST_DONE 4
`define ST_MATCH 5
`define ST_SETTLED 6

// pattern config fields
`define PCFG_EN 0
`define PCFG_LEN_LSB 1
`define PCFG_LEN_MSB 3

// reset values
`define RST_LIMIT 6'h0F
`define RST_PAT_LEN 3'h3
`define RST_PAT_VAL 64'h0101010101010101
`endif

// [packet_fifo_pkg.sv]
package packet_fifo_pkg;
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_STDBY,
    MODE_TX,
    MODE_RX
  } op_mode_t;
endpackage

// [packet_fifo_sync_detect.sv]
`timescale 1ns/1ps
`include "packet_fifo_map.svh"
module packet_fifo_sync_detect #(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // spi chip select pin
  input wire logic spi_cs_n_i,
  // bit link
  input wire logic bit_clk_i,
  input wire logic rx_bit_i,
  output logic tx_bit_o,
  // flags
  output logic queue_vacant_o,
  output logic queue_all_occupied_o,
  output logic queue_level_indicator_o,
  output logic queue_overflow_flag_o,
  output logic frame_transmit_done_o,
  output logic pattern_match_flag_o,
  output logic op_mode_settled_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic bclk_s1_r, bclk_s2_r, bclk_s3_r;
  logic rxd_s1_r, rxd_s2_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= spi_cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
    end else begin
      bclk_s1_r <= bit_clk_i;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
    end else begin
      rxd_s1_r <= rx_bit_i;
      rxd_s2_r <= rxd_s1_r;
    end
  end
  logic cs_fall, bit_tick;
  assign cs_fall = cs_s3_r & ~cs_s2_r;
  assign bit_tick = bclk_s2_r & ~bclk_s3_r;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  packet_fifo_pkg::op_mode_t mode_r, mode_new;
  logic [5:0] limit_r;
  logic pat_en_r;
  logic [2:0] pat_len_r;
  logic [63:0] pat_val_r;
  logic mode_wr, st_wr, ovf_clr, done_clr;
  assign mode_new = packet_fifo_pkg::op_mode_t'(wdata_i[1:0]);
  assign mode_wr = wr_i && addr_i == `REG_MODE && mode_new != mode_r;
  assign st_wr = wr_i && addr_i == `REG_STATUS;
  assign ovf_clr = st_wr && wdata_i[`ST_OVF];
  assign done_clr = st_wr && wdata_i[`ST_DONE];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= packet_fifo_pkg::MODE_STDBY;
      limit_r <= `RST_LIMIT;
      pat_en_r <= 1'b1;
      pat_len_r <= `RST_PAT_LEN;
      pat_val_r <= `RST_PAT_VAL;
    end else if (wr_i) begin
      unique case (addr_i)
        `REG_MODE: mode_r <= mode_new;
        `REG_LIMIT: limit_r <= wdata_i[5:0];
        `REG_PAT_CFG: begin
          pat_en_r <= wdata_i[`PCFG_EN];
          pat_len_r <= wdata_i[`PCFG_LEN_MSB:`PCFG_LEN_LSB];
        end
        `REG_PAT_LO: pat_val_r[31:0] <= wdata_i;
        `REG_PAT_HI: pat_val_r[63:32] <= wdata_i;
        default: ;
      endcase
    end
  end

  // settled one cycle after the mode write lands
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_mode_settled_o <= 1'b1;
    end else begin
      op_mode_settled_o <= ~mode_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // queue storage and pointers
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push_req, pop_req, push_ok, pop_ok, flush;
  logic [7:0] push_data;
  logic ser_load, rx_push, bus_pop, bus_push;
  logic [7:0] rx_sr_r;
  logic full, empty;
  assign full = cnt_r == DEPTH_C;
  assign empty = cnt_r == '0;

  // mode-driven clearing: kept for low-power swaps, into rx, out of tx
  assign flush = ovf_clr
    || (mode_wr && (mode_new == packet_fifo_pkg::MODE_RX
    || mode_r == packet_fifo_pkg::MODE_TX));

  assign bus_push = wr_i && addr_i == `REG_DATA
    && mode_r != packet_fifo_pkg::MODE_RX;
  assign bus_pop = rd_i && addr_i == `REG_DATA;
  assign push_req = bus_push | rx_push;
  assign push_data = rx_push ? {rx_sr_r[6:0], rxd_s2_r} : wdata_i[7:0];
  assign pop_req = ser_load | bus_pop;
  assign pop_ok = pop_req && !empty && !flush;
  assign push_ok = push_req && (!full || pop_ok) && !flush;

  always_comb begin
    cnt_nxt = cnt_r;
    if (flush) begin
      cnt_nxt = '0;
    end else if (push_ok && !pop_ok) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop_ok && !push_ok) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_ok) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (flush) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push_ok) begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
        end
        if (pop_ok) begin
          rd_ptr_r <= rd_ptr_r + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // queue flags
  logic full_seen_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_all_occupied_o <= 1'b0;
    end else begin
      queue_all_occupied_o <= cnt_nxt == DEPTH_C;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_vacant_o <= 1'b1;
    end else begin
      if (cs_s2_r || cs_fall) begin
        queue_vacant_o <= cnt_nxt == '0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_seen_r <= 1'b0;
    end else begin
      if (cnt_nxt == DEPTH_C) begin
        full_seen_r <= 1'b1;
      end else if (cnt_nxt == '0) begin
        full_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_level_indicator_o <= 1'b0;
    end else if ((push_ok || pop_ok || flush)
                 && (!full_seen_r || cnt_nxt == '0)) begin
      queue_level_indicator_o <= cnt_nxt > {1'b0, limit_r};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_overflow_flag_o <= 1'b0;
    end else begin
      if (push_req && full && !pop_ok) begin
        queue_overflow_flag_o <= 1'b1;
      end else if (ovf_clr) begin
        queue_overflow_flag_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit serializer
  logic [7:0] bit_serializer_r;
  logic [3:0] ser_bits_r;
  logic [63:0] pat_sr_r;
  logic [6:0] pat_left_r;
  logic tx_on;
  assign tx_on = mode_r == packet_fifo_pkg::MODE_TX;
  // no pop while a pattern bit is being shifted, or the byte is lost
  assign ser_load = tx_on && ser_bits_r == 4'h0 && !empty
    && !(bit_tick && pat_left_r != 7'h00);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_serializer_r <= 8'h00;
      ser_bits_r <= 4'h0;
      pat_sr_r <= 64'h0000000000000000;
      pat_left_r <= 7'h00;
      tx_bit_o <= 1'b0;
    end else if (mode_wr) begin
      ser_bits_r <= 4'h0;
      pat_sr_r <= pat_val_r;
      pat_left_r <= (mode_new == packet_fifo_pkg::MODE_TX && pat_en_r)
        ? {1'b0, pat_len_r, 3'h0} + 7'h08 : 7'h00;
    end else if (tx_on) begin
      if (bit_tick && pat_left_r != 7'h00) begin
        tx_bit_o <= pat_sr_r[63];
        pat_sr_r <= {pat_sr_r[62:0], 1'b0};
        pat_left_r <= pat_left_r - 7'h01;
      end else if (ser_load && pop_ok) begin
        bit_serializer_r <= mem[rd_ptr_r];
        ser_bits_r <= 4'h8;
      end else if (bit_tick && ser_bits_r != 4'h0) begin
        tx_bit_o <= bit_serializer_r[7];
        bit_serializer_r <= {bit_serializer_r[6:0], 1'b0};
        ser_bits_r <= ser_bits_r - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_transmit_done_o <= 1'b0;
    end else if (tx_on && bit_tick && pat_left_r == 7'h00
                 && ser_bits_r == 4'h1 && empty) begin
      frame_transmit_done_o <= 1'b1;
    end else if (done_clr || mode_wr) begin
      frame_transmit_done_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive deserializer and pattern recognizer
  logic rx_on, rx_tick, match_now, armed_r;
  logic [63:0] hist_r, hist_nxt, pat_mask, pat_exp;
  logic [5:0] drop;
  logic [2:0] rx_bits_r;
  assign rx_on = mode_r == packet_fifo_pkg::MODE_RX;
  assign rx_tick = rx_on && bit_tick && !mode_wr;
  assign hist_nxt = {hist_r[62:0], rxd_s2_r};
  assign drop = {3'h7 - pat_len_r, 3'h0};
  assign pat_mask = 64'hFFFFFFFFFFFFFFFF >> drop;
  assign pat_exp = pat_val_r >> drop;
  assign match_now = pat_en_r && rx_tick
    && (hist_nxt & pat_mask) == pat_exp;
  assign rx_push = rx_tick && armed_r && !match_now
    && rx_bits_r == 3'h7;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_r <= 64'h0000000000000000;
    end else if (!rx_on || mode_wr) begin
      hist_r <= 64'h0000000000000000;
    end else if (rx_tick) begin
      hist_r <= hist_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sr_r <= 8'h00;
      rx_bits_r <= 3'h0;
      armed_r <= 1'b0;
    end else if (!rx_on || mode_wr) begin
      rx_bits_r <= 3'h0;
      armed_r <= 1'b0;
    end else if (rx_tick) begin
      if (match_now || !pat_en_r) begin
        armed_r <= 1'b1;
      end
      if (match_now) begin
        rx_bits_r <= 3'h0;
      end else if (armed_r) begin
        rx_sr_r <= {rx_sr_r[6:0], rxd_s2_r};
        rx_bits_r <= rx_bits_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pattern_match_flag_o <= 1'b0;
    end else if (match_now) begin
      pattern_match_flag_o <= 1'b1;
    end else if (!rx_on || mode_wr || (!empty && cnt_nxt == '0)) begin
      pattern_match_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      unique case (addr_i)
        `REG_DATA: rdata_o <= empty ? 32'h00000000 : {24'h000000,
          mem[rd_ptr_r]};
        `REG_STATUS: rdata_o <= {25'h0000000, op_mode_settled_o,
          pattern_match_flag_o, frame_transmit_done_o,
          queue_overflow_flag_o, queue_level_indicator_o,
          queue_all_occupied_o, queue_vacant_o};
        `REG_LIMIT: rdata_o <= {26'h0000000, limit_r};
        `REG_PAT_CFG: rdata_o <= {28'h0000000, pat_len_r, pat_en_r};
        `REG_PAT_LO: rdata_o <= pat_val_r[31:0];
        `REG_PAT_HI: rdata_o <= pat_val_r[63:32];
        `REG_MODE: rdata_o <= {30'h00000000, mode_r};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "packet_fifo_map.svh"
module tb;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, spi_cs_n_i = 1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, pat;
  logic bit_clk_i, rx_bit_i, tx_bit_o, run = 0, rd_q = 0;
  logic queue_vacant_o, queue_all_occupied_o, queue_level_indicator_o;
  logic queue_overflow_flag_o, frame_transmit_done_o;
  logic pattern_match_flag_o, op_mode_settled_o;
  logic [39:0] rx_data = 40'h0;
  logic [15:0] cap;
  logic [7:0] q[$], b, d1, d2;
  logic [31:0] exp_q[$];
  int fail_count = 0, checks_done = 0;
  packet_fifo_sync_detect #(.DEPTH(64)) dut (.*);
  modem_model far (.run_i(run), .tx_bit_i(tx_bit_o), .rx_data_i(rx_data),
    .bit_clk_o(bit_clk_i), .rx_bit_o(rx_bit_i), .cap_o(cap));
  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic mode(input logic [1:0] m);
    wr(`REG_MODE, {30'h0, m});
    for (int k = 0; k < 9 && !op_mode_settled_o; k++) @(posedge clk_i);
  endtask
  task automatic frame(input int nb);
    run <= 1'b1;
    repeat (nb) @(posedge bit_clk_i);
    @(posedge clk_i);
    run <= 1'b0;
    repeat (60) @(posedge clk_i);
  endtask
  // read data watcher
  always @(posedge clk_i) rd_q <= rd_i;
  always @(negedge clk_i) begin
    if (rd_q) chk(rdata_o, exp_q.pop_front());
  end
  initial begin
    #100000;
    fail_count++;
    results();
  end
  ////////////////////////////////
  initial begin
    b = 8'($urandom(32'h0095));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`REG_STATUS, 32'h41);
    repeat (64) begin
      b = 8'($urandom);
      q.push_back(b);
      wr(`REG_DATA, {24'h0, b});
    end
    rd(`REG_STATUS, 32'h46);
    wr(`REG_DATA, 32'h5A);
    rd(`REG_STATUS, 32'h4E);
    for (int i = 0; i < 64; i++) begin
      rd(`REG_DATA, {24'h0, q.pop_front()});
      if (i == 59) rd(`REG_STATUS, 32'h4C);
    end
    rd(`REG_DATA, 32'h0);
    rd(`REG_STATUS, 32'h49);
    wr(`REG_DATA, 32'h77);
    wr(`REG_STATUS, 32'h8);
    rd(`REG_STATUS, 32'h41);
    wr(`REG_LIMIT, 32'h2);
    repeat (3) wr(`REG_DATA, 32'h33);
    rd(`REG_STATUS, 32'h44);
    wr(`REG_LIMIT, 32'h5);
    rd(`REG_STATUS, 32'h44);
    wr(`REG_DATA, 32'h33);
    rd(`REG_STATUS, 32'h40);
    mode(2'h0);
    mode(2'h1);
    rd(`REG_STATUS, 32'h40);
    pat = $urandom | 32'h81010101;
    {d1, d2} = 16'($urandom);
    rx_data = {8'h00, pat[31:16], d1, d2};
    wr(`REG_PAT_CFG, 32'h3);
    wr(`REG_PAT_HI, pat);
    mode(2'h3);
    rd(`REG_STATUS, 32'h41);
    frame(40);
    rd(`REG_STATUS, 32'h60);
    mode(2'h1);
    rd(`REG_STATUS, 32'h40);
    rd(`REG_DATA, {24'h0, d1});
    rd(`REG_DATA, {24'h0, d2});
    wr(`REG_PAT_CFG, 32'h1);
    b = 8'($urandom);
    wr(`REG_DATA, {24'h0, b});
    mode(2'h2);
    frame(16);
    chk({16'h0, cap}, {16'h0, pat[31:24], b});
    rd(`REG_STATUS, 32'h51);
    mode(2'h1);
    rd(`REG_STATUS, 32'h41);
    spi_cs_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(`REG_DATA, 32'h11);
    rd(`REG_STATUS, 32'h41);
    spi_cs_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    spi_cs_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(`REG_STATUS, 32'h40);
    results();
  end
endmodule
